// ===== cpu_general_register_file.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_general_register_file (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // mode pins
  input wire logic [2:0] mode_select_pins,
  // general register access
  input wire regfile_pkg::reg_write_t wr_req,
  input wire regfile_pkg::reg_read_t rd_a,
  input wire regfile_pkg::reg_read_t rd_b,
  input wire logic [2:0] addr_idx,
  // stack pointer control
  input wire regfile_pkg::sp_op_t sp_op,
  // frame pointer control
  input wire logic frame_load,
  input wire logic [15:0] frame_data,
  // control registers
  input wire logic ip_load,
  input wire logic [15:0] ip_data,
  input wire logic status_load,
  input wire logic status_byte,
  input wire logic [15:0] status_data,
  input wire regfile_pkg::pages_t pages,
  // read results
  output logic [15:0] rd_a_data,
  output logic [15:0] rd_b_data,
  output logic [15:0] addr_word,
  output logic [15:0] stack_ptr,
  output logic [15:0] frame_ptr,
  output logic [15:0] instruction_pointer,
  output logic [15:0] status_word_register,
  // mode and addresses
  output regfile_pkg::cpu_mode_t mode,
  output logic [23:0] code_addr,
  output logic [19:0] code_pin_addr
);
  import regfile_pkg::*;

  typedef struct packed {
    logic [REG_COUNT-1:0][15:0] gr;
    logic [15:0] ip;
    logic [15:0] status;
    cpu_mode_t mode;
    logic [15:0] rd_a;
    logic [15:0] rd_b;
    logic [15:0] addr;
    logic [23:0] caddr;
    logic [19:0] cpin;
  } state_t;

  state_t cur;
  state_t next_st;
  logic [REG_COUNT-1:0][15:0] next_gr;
  logic [23:0] ea;
  logic [19:0] pa;

  // ----------------------------------------------------------------
  // read helper
  // ----------------------------------------------------------------
  function automatic logic [15:0] read_data(input logic [15:0] w, input reg_read_t r);
    logic [15:0] res;
    res = w;
    if (r.byte_sel) begin
      res = r.high_byte ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // code address from the next instruction pointer
  // ----------------------------------------------------------------
  eff_addr_gen code_gen (
    .mode(next_st.mode),
    .page(pages.code_page),
    .offset(next_st.ip),
    .eff_addr(ea),
    .pin_addr(pa)
  );

  // ----------------------------------------------------------------
  // general register updates, one per entry
  // ----------------------------------------------------------------
  // write port first, then implicit stack and frame updates override
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
      always_comb begin
        next_gr[gi] = cur.gr[gi];
        if (wr_req.en && wr_req.idx == 3'(gi)) begin
          if (!wr_req.byte_sel) begin
            next_gr[gi] = wr_req.data;
          end else if (wr_req.high_byte) begin
            next_gr[gi][15:8] = wr_req.data[7:0];
          end else begin
            next_gr[gi][7:0] = wr_req.data[7:0];
          end
        end
        if (3'(gi) == STACK_PTR_IDX) begin
          case (sp_op)
            SP_PRE_DEC: begin
              next_gr[gi] = cur.gr[gi] - WORD_STEP;
            end
            SP_POST_INC: begin
              next_gr[gi] = cur.gr[gi] + WORD_STEP;
            end
            SP_NONE: begin
            end
            default: begin
            end
          endcase
        end
        if (3'(gi) == FRAME_PTR_IDX && frame_load) begin
          next_gr[gi] = frame_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = cur;
    next_st.gr = next_gr;
    if (ip_load) begin
      next_st.ip = ip_data;
    end
    if (status_load) begin
      if (status_byte) begin
        next_st.status[7:0] = status_data[7:0] & STATUS_WRITE_MASK[7:0];
      end else begin
        next_st.status = status_data & STATUS_WRITE_MASK;
      end
    end
    next_st.rd_a = read_data(next_gr[rd_a.idx], rd_a);
    next_st.rd_b = read_data(next_gr[rd_b.idx], rd_b);
    next_st.addr = next_gr[addr_idx];
    next_st.caddr = ea;
    next_st.cpin = pa;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // mode pins sampled while reset is held
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur.gr <= '{default: GREG_RESET};
      cur.ip <= IP_RESET;
      cur.status <= STATUS_RESET;
      cur.mode <= (mode_select_pins == MODE_MIN_CODE) ? MODE_MIN : MODE_MAX;
      cur.rd_a <= GREG_RESET;
      cur.rd_b <= GREG_RESET;
      cur.addr <= GREG_RESET;
      cur.caddr <= 24'h00_0000;
      cur.cpin <= 20'h0_0000;
    end else if (clk_en) begin
      cur <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from state
  // ----------------------------------------------------------------
  assign rd_a_data = cur.rd_a;
  assign rd_b_data = cur.rd_b;
  assign addr_word = cur.addr;
  assign stack_ptr = cur.gr[STACK_PTR_IDX];
  assign frame_ptr = cur.gr[FRAME_PTR_IDX];
  assign instruction_pointer = cur.ip;
  assign status_word_register = cur.status;
  assign mode = cur.mode;
  assign code_addr = cur.caddr;
  assign code_pin_addr = cur.cpin;
endmodule
`default_nettype wire

// ===== regfile_pkg.sv
package regfile_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned REG_COUNT = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned PAGE_W = 8;
  localparam int unsigned EA_W = 24;
  localparam int unsigned PIN_ADDR_W = 20;
  localparam int unsigned MODE_PIN_W = 3;

  // ----------------------------------------------------------------
  // fixed register roles
  // ----------------------------------------------------------------
  localparam logic [2:0] FRAME_PTR_IDX = 3'h6;
  localparam logic [2:0] STACK_PTR_IDX = 3'h7;

  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [15:0] GREG_RESET = 16'h0000;
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0700;
  localparam logic [15:0] STATUS_WRITE_MASK = 16'h870F;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [2:0] MODE_MIN_CODE = 3'h1;
  localparam logic [7:0] PAGE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_MIN = 2'b01,
    MODE_MAX = 2'b10
  } cpu_mode_t;

  typedef enum logic [2:0] {
    SP_NONE = 3'b001,
    SP_PRE_DEC = 3'b010,
    SP_POST_INC = 3'b100
  } sp_op_t;

  // write request from the datapath
  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic byte_sel;
    logic high_byte;
    logic [15:0] data;
  } reg_write_t;

  // read port request
  typedef struct packed {
    logic [2:0] idx;
    logic byte_sel;
    logic high_byte;
  } reg_read_t;

  // page register values from outside
  typedef struct packed {
    logic [7:0] code_page;
    logic [7:0] data_page;
    logic [7:0] ext_page;
    logic [7:0] stack_page;
  } pages_t;

endpackage

// ===== eff_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
module eff_addr_gen (
  // mode and page
  input wire regfile_pkg::cpu_mode_t mode,
  input wire logic [7:0] page,
  // offset word
  input wire logic [15:0] offset,
  // result
  output logic [23:0] eff_addr,
  output logic [19:0] pin_addr
);
  import regfile_pkg::*;

  // ----------------------------------------------------------------
  // page concatenation
  // ----------------------------------------------------------------
  // page joins the offset only in maximum mode
  always_comb begin
    if (mode == MODE_MAX) begin
      eff_addr = {page, offset};
    end else begin
      eff_addr = {PAGE_ZERO, offset};
    end
    pin_addr = eff_addr[19:0];
  end
endmodule
`default_nettype wire

// ===== regfile_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module regfile_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // requests
  input wire logic [2:0] mode_select_pins,
  input wire regfile_pkg::reg_write_t wr_req,
  input wire regfile_pkg::reg_read_t rd_a,
  input wire regfile_pkg::sp_op_t sp_op,
  input wire logic ip_load,
  input wire logic [15:0] ip_data,
  // results
  input wire logic [15:0] rd_a_data,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] instruction_pointer,
  input wire logic [15:0] status_word_register,
  input wire regfile_pkg::cpu_mode_t mode,
  input wire logic [23:0] code_addr,
  input wire logic [19:0] code_pin_addr
);
  import regfile_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // read-back, stack steps, loads, reserved status bits, code addresses and mode latch
  word_readback_a: assert property (
    clk_en && wr_req.en && !wr_req.byte_sel && wr_req.idx < 3'h6 && rd_a == {wr_req.idx, 2'b00}
    |=> rd_a_data == $past(wr_req.data)) else $error("word write not read back");
  sp_predec_a: assert property (
    clk_en && sp_op == SP_PRE_DEC |=> stack_ptr == $past(stack_ptr) - WORD_STEP) else $error("bad pre-decrement");
  sp_postinc_a: assert property (
    clk_en && sp_op == SP_POST_INC |=> stack_ptr == $past(stack_ptr) + WORD_STEP) else $error("bad post-increment");
  ip_load_a: assert property (
    clk_en && ip_load |=> instruction_pointer == $past(ip_data)) else $error("ip not loaded");
  status_rsv_a: assert property (
    (status_word_register & ~STATUS_WRITE_MASK) == 16'h0000) else $error("reserved status bit set");
  min_page_a: assert property (
    mode == MODE_MIN |-> code_addr == {PAGE_ZERO, instruction_pointer}) else $error("page used in minimum mode");
  pin_addr_a: assert property (
    code_pin_addr == code_addr[19:0]) else $error("pin address not low bits");
  mode_latch_a: assert property (
    $fell(reset) |-> mode == (($past(mode_select_pins) == MODE_MIN_CODE) ? MODE_MIN : MODE_MAX) ##1 $stable(mode))
    else $error("mode not latched");
  // main scenarios
  cover property (sp_op == SP_PRE_DEC ##1 sp_op == SP_POST_INC);
  cover property (mode == MODE_MAX && ip_load);
  cover property (wr_req.en && wr_req.byte_sel);
endmodule
bind cpu_general_register_file regfile_monitor regfile_monitor_i (.*);
`default_nettype wire

// ===== strap_model.sv
`timescale 1ns/1ps
`default_nettype none
module strap_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // wanted straps and page
  input wire logic [2:0] strap,
  input wire logic [7:0] cpage,
  // to the core
  output regfile_pkg::pages_t pages = '0,
  output logic [2:0] mode_select_pins = 3'h1
);
  // straps move only outside reset, page follows each edge
  always_ff @(posedge clk_sys) begin
    if (!reset) begin
      mode_select_pins <= strap;
    end
    pages <= {cpage, 24'h00_0000};
  end
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import regfile_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [2:0] strap = 3'h1;
  logic [7:0] cpage = 8'h00;
  reg_write_t wr_req = '0;
  reg_read_t rd_a = '0;
  reg_read_t rd_b = '0;
  logic [2:0] addr_idx = 3'h0;
  logic clk_en = 1'b1;
  sp_op_t sp_op = SP_NONE;
  logic frame_load = 1'b0, ip_load = 1'b0, status_load = 1'b0, status_byte = 1'b0;
  logic [15:0] frame_data = 16'h0000, ip_data = 16'h0000, status_data = 16'h0000;
  logic [15:0] rd_a_data, rd_b_data, addr_word, stack_ptr, frame_ptr, instruction_pointer, status_word_register;
  logic [2:0] mode_select_pins;
  pages_t pages;
  cpu_mode_t mode;
  logic [23:0] code_addr;
  logic [19:0] code_pin_addr;
  int error_cnt = 0;
  int samples_checked = 0;
  // system clock
  initial forever #12.5 clk_sys = ~clk_sys;
  strap_model strap_model_i (.*);
  cpu_general_register_file cpu_general_register_file_i (.*);
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  task results;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // request edge passes, strobes drop, outputs settle
  task done;
    @(posedge clk_sys);
    wr_req.en <= 1'b0;
    sp_op <= SP_NONE;
    ip_load <= 1'b0;
    status_load <= 1'b0;
    #1;
  endtask
  task do_reset(input logic [2:0] p);
    @(posedge clk_sys);
    strap <= p;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(mode, (p == MODE_MIN_CODE) ? MODE_MIN : MODE_MAX);
    chk(status_word_register, STATUS_RESET);
    chk(stack_ptr, GREG_RESET);
  endtask
  task acc(input reg_write_t w, input reg_read_t a, input reg_read_t b, input logic [15:0] ea, input logic [15:0] eb);
    @(posedge clk_sys);
    wr_req <= w;
    rd_a <= a;
    rd_b <= b;
    addr_idx <= a.idx;
    done;
    chk(rd_a_data, ea);
    chk(rd_b_data, eb);
    chk(addr_word, ea);
  endtask
  task t_regs;
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 16'hA5C3 + 16'(i) * 16'h1111;
      acc('{1'b1, 3'(i), 1'b0, 1'b0, v}, '{3'(i), 1'b0, 1'b0}, '{3'(i), 1'b1, 1'b0}, v, {8'h00, v[7:0]});
    end
    acc('{1'b1, 3'h2, 1'b1, 1'b1, 16'h007E}, '{3'h2, 1'b0, 1'b0}, '{3'h2, 1'b1, 1'b1}, 16'h7EE5, 16'h007E);
    acc('{1'b1, 3'h2, 1'b1, 1'b0, 16'hFF19}, '{3'h2, 1'b0, 1'b0}, '{3'h2, 1'b1, 1'b0}, 16'h7E19, 16'h0019);
  endtask
  task t_stack;
    @(posedge clk_sys);
    sp_op <= SP_PRE_DEC;
    wr_req <= '{1'b1, 3'h7, 1'b0, 1'b0, 16'hFFFF};
    frame_load <= 1'b1;
    frame_data <= 16'hBEEF;
    rd_a <= '{3'h6, 1'b0, 1'b0};
    @(posedge clk_sys);
    sp_op <= SP_POST_INC;
    wr_req.en <= 1'b0;
    frame_load <= 1'b0;
    #1;
    chk(stack_ptr, 16'h1D38);
    chk(frame_ptr, 16'hBEEF);
    chk(rd_a_data, 16'hBEEF);
    done;
    chk(stack_ptr, 16'h1D3A);
  endtask
  task t_ctl(input logic [7:0] pg, input logic [15:0] ip, input logic [23:0] ea);
    @(posedge clk_sys);
    cpage <= pg;
    @(posedge clk_sys);
    ip_load <= 1'b1;
    ip_data <= ip;
    status_load <= 1'b1;
    status_byte <= 1'b0;
    status_data <= 16'hFFFF;
    done;
    chk(instruction_pointer, ip);
    chk(code_addr, ea);
    chk(code_pin_addr, ea[19:0]);
    chk(status_word_register, STATUS_WRITE_MASK);
    @(posedge clk_sys);
    status_load <= 1'b1;
    status_byte <= 1'b1;
    status_data <= 16'h00F0;
    done;
    chk(status_word_register, 16'h8700);
  endtask
  // load while clock enable is low must leave the pointer alone
  task t_hold(input logic [15:0] ip_old);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    ip_load <= 1'b1;
    ip_data <= 16'h1111;
    done;
    chk(instruction_pointer, ip_old);
    @(posedge clk_sys);
    clk_en <= 1'b1;
  endtask
  // main sequence
  initial begin
    do_reset(3'h1);
    t_regs;
    t_stack;
    t_ctl(8'h5A, 16'h4321, 24'h00_4321);
    t_hold(16'h4321);
    do_reset(3'h4);
    t_ctl(8'h5A, 16'hFFFE, 24'h5A_FFFE);
    results;
  end
endmodule
`default_nettype wire
